/* common/mpgpio_pkg.sv */
// Purpose: constants for the three-port general purpose I/O block
// Assumes: AHB-Lite register access, one 32-bit word per register
// Notes: port two and control words sit at chosen offsets
//
// Behaviour
// - Port one: seven pins, bitwise direction
// - Reset clears port one direction and latch
// - Port one bit one interrupts on both edges
// - Bit zero selects port or interrupt zero
// - Port two: three pins, latch resets high
// - Dual-clock mode gives bits one, two to resonator
// - Port two bit zero falling edge sets latch
// - Port two reads latch or pin levels
// - Port two upper read bits are indeterminate
// - STOP floats port two bit zero output
// - Reset: port three digital inputs, analog disabled
// - Analog selection overrides port three latch, direction
// - Port three output bits drive latch value
// - Analog and output pins read latch, inputs read pins
// - Writes never drive analog-selected pins
// - Input-mode bits read back pin levels unless analog-selected
// - Port one shared: divider, interrupt one, zero
package mpgpio_pkg;
  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_P1_DATA = 8'h01;
  localparam logic [7:0] IDX_P3_DATA = 8'h03;
  localparam logic [7:0] IDX_P1_DIR = 8'h09;
  localparam logic [7:0] IDX_P3_DIR = 8'h0A;
  // Register byte addresses
  localparam logic [7:0] ADDR_P1_DATA = {IDX_P1_DATA[5:0], 2'b00};
  localparam logic [7:0] ADDR_P3_DATA = {IDX_P3_DATA[5:0], 2'b00};
  localparam logic [7:0] ADDR_P1_DIR = {IDX_P1_DIR[5:0], 2'b00};
  localparam logic [7:0] ADDR_P3_DIR = {IDX_P3_DIR[5:0], 2'b00};
  localparam logic [7:0] ADDR_P2_DATA = 8'h40;
  localparam logic [7:0] ADDR_P2_PIN = 8'h44;
  localparam logic [7:0] ADDR_CTRL = 8'h48;
  localparam logic [7:0] ADDR_EVENT = 8'h4C;
  // ==========================================================
  // Widths and reset values
  localparam int P1_W = 7;
  localparam int P2_W = 3;
  localparam int P3_W = 8;
  localparam logic [6:0] P1_LATCH_RST = 7'h00;
  localparam logic [6:0] P1_DIR_RST = 7'h00;
  localparam logic [2:0] P2_LATCH_RST = 3'h7;
  localparam logic [7:0] P3_LATCH_RST = 8'h00;
  localparam logic [7:0] P3_DIR_RST = 8'h00;
  // ==========================================================
  // Control word fields
  localparam int CTRL_EXT_INTERRUPT_ZERO_SEL = 0;
  localparam int CTRL_AIN_DIS = 1;
  localparam int CTRL_DUAL_CLK = 2;
  localparam int CTRL_CH_LSB = 4;
  localparam int CTRL_CH_W = 3;
  localparam logic [7:0] CTRL_RST = 8'h02;
  // Event word fields (write one to clear)
  localparam int EV_EXT_INTERRUPT_ZERO = 0;
  localparam int EV_EXT_INTERRUPT_ONE = 1;
  localparam int EV_P20 = 2;
  // Analog channels map to port three bits two..seven
  localparam int AIN_BASE = 2;
  localparam int AIN_COUNT = 6;
endpackage

/* verilog/mpgpio_top.sv */
// Purpose: port one, two and three pin logic with AHB-Lite registers
// Assumes: pins synchronous to I_CLK, zero wait state bus
// Notes: interrupt latches are exported as sticky event outputs
`timescale 1ns/10ps
module mpgpio_top
  import mpgpio_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // AHB-Lite slave
  input wire logic I_HSEL,
  input wire logic [7:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Port one pins
  input wire logic [6:0] I_P1_PIN,
  output logic [6:0] O_P1_PIN,
  output logic [6:0] O_P1_OE,
  // Port two pins
  input wire logic [2:0] I_P2_PIN,
  output logic [2:0] O_P2_PIN,
  output logic [2:0] O_P2_OE,
  // Port three pins
  input wire logic [7:0] I_P3_PIN,
  output logic [7:0] O_P3_PIN,
  output logic [7:0] O_P3_OE,
  output logic [7:0] O_P3_ANALOG,
  // System side
  input wire logic I_STOP_MODE,
  input wire logic I_OUTPUT_DRIVE_ENABLE,
  input wire logic I_DIVIDER_OUTPUT,
  input wire logic I_CONVERTING,
  output logic O_EXT_INTERRUPT_ZERO,
  output logic O_EXT_INTERRUPT_ONE,
  output logic O_P20_EVENT,
  output logic O_RESONATOR_MODE
);

  // ==========================================================
  // Bus address phase capture
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic [31:0] rdata_next;
  logic take;

  logic [6:0] p1_latch_reg;
  logic [6:0] p1_dir_reg;
  logic [2:0] p2_latch_reg;
  logic [7:0] p3_latch_reg;
  logic [7:0] p3_dir_reg;
  logic [7:0] ctrl_reg;
  logic [2:0] event_reg;
  logic [6:0] p1_in_prev_reg;
  logic p20_prev_reg;
  logic [7:0] analog_sel;

  function automatic logic [31:0] word8(input logic [7:0] v);
    word8 = {24'h000000, v};
  endfunction

  // Selected bits read the latch, the others the pin
  function automatic logic [7:0] pick8(input logic [7:0] sel,
    input logic [7:0] lat, input logic [7:0] pin);
    pick8 = (sel & lat) | (~sel & pin);
  endfunction

  assign take = I_HSEL & I_HREADY & I_HTRANS[1];

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= take & I_HWRITE;
      addr_reg <= I_HADDR;
    end
  end

  // ==========================================================
  // Analog channel decode
  always_comb
  begin
    analog_sel = 8'h00;
    if (!ctrl_reg[CTRL_AIN_DIS] &&
        ctrl_reg[CTRL_CH_LSB +: CTRL_CH_W] < 3'(AIN_COUNT))
      analog_sel[AIN_BASE + int'(ctrl_reg[CTRL_CH_LSB +: CTRL_CH_W])]
        = 1'b1;
  end

  // ==========================================================
  // Elaboration checks
  if (AIN_BASE + AIN_COUNT > P3_W)
  begin : g_ain_range
    $error("analog channels run past port three");
  end
  if (AIN_COUNT > (1 << CTRL_CH_W))
  begin : g_ain_code
    $error("analog channel code too narrow");
  end
  if (P1_W != 7 || P2_W != 3 || P3_W != 8)
  begin : g_port_width
    $error("port widths do not match the pins");
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      p1_latch_reg <= P1_LATCH_RST;
      p1_dir_reg <= P1_DIR_RST;
      p2_latch_reg <= P2_LATCH_RST;
      p3_latch_reg <= P3_LATCH_RST;
      p3_dir_reg <= P3_DIR_RST;
      ctrl_reg <= CTRL_RST;
    end
    else if (wr_pend_reg)
    begin
      unique case (addr_reg)
        ADDR_P1_DATA: p1_latch_reg <= I_HWDATA[6:0];
        ADDR_P1_DIR: p1_dir_reg <= I_HWDATA[6:0];
        ADDR_P2_DATA: p2_latch_reg <= I_HWDATA[2:0];
        // Analog pins keep latch but never drive it
        ADDR_P3_DATA: p3_latch_reg <= I_HWDATA[7:0];
        ADDR_P3_DIR: p3_dir_reg <= I_HWDATA[7:0];
        ADDR_CTRL: ctrl_reg <= I_HWDATA[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Edge events; a new edge beats a clear in the same cycle
  logic [2:0] ev_set;
  logic [2:0] ev_clr;
  always_comb
  begin
    ev_set[EV_EXT_INTERRUPT_ZERO] = ctrl_reg[CTRL_EXT_INTERRUPT_ZERO_SEL] &
      (I_P1_PIN[0] ^ p1_in_prev_reg[0]);
    ev_set[EV_EXT_INTERRUPT_ONE] = I_P1_PIN[1] ^ p1_in_prev_reg[1];
    ev_set[EV_P20] = p20_prev_reg & ~I_P2_PIN[0];
    ev_clr = (wr_pend_reg && addr_reg == ADDR_EVENT) ?
      I_HWDATA[2:0] : 3'h0;
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      // Baseline from the pins, so release brings no false edge
      p1_in_prev_reg <= I_P1_PIN;
      p20_prev_reg <= I_P2_PIN[0];
      event_reg <= 3'h0;
    end
    else
    begin
      p1_in_prev_reg <= I_P1_PIN;
      p20_prev_reg <= I_P2_PIN[0];
      event_reg <= (event_reg & ~ev_clr) | ev_set;
    end
  end

  // ==========================================================
  // Read mux, registered for the data phase
  always_comb
  begin
    rdata_next = 32'h00000000;
    unique case (I_HADDR)
      ADDR_P1_DATA: rdata_next = word8(pick8({1'b0, p1_dir_reg},
        {1'b0, p1_latch_reg}, {1'b0, I_P1_PIN}));
      ADDR_P1_DIR: rdata_next = word8({1'b0, p1_dir_reg});
      // Upper bits modelled as zero; software must ignore them
      ADDR_P2_DATA: rdata_next = word8({5'h00, p2_latch_reg});
      ADDR_P2_PIN: rdata_next = word8({5'h00, I_P2_PIN});
      // Analog and output bits read the latch, inputs the pin
      ADDR_P3_DATA: rdata_next = word8(pick8(analog_sel | p3_dir_reg,
        p3_latch_reg, I_P3_PIN));
      ADDR_P3_DIR: rdata_next = word8(p3_dir_reg);
      ADDR_CTRL: rdata_next = word8(ctrl_reg);
      ADDR_EVENT: rdata_next = word8({5'h00, event_reg});
      default: rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      O_HRDATA <= 32'h00000000;
    else if (take && !I_HWRITE)
      O_HRDATA <= rdata_next;
  end

  always_ff @(posedge I_CLK)
  begin
    O_HREADYOUT <= 1'b1;
    O_HRESP <= 1'b0;
  end

  // ==========================================================
  // Pin drivers
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      O_P1_PIN <= 7'h00;
      O_P1_OE <= 7'h00;
      O_P2_PIN <= 3'h7;
      O_P2_OE <= 3'h0;
      O_P3_PIN <= 8'h00;
      O_P3_OE <= 8'h00;
      O_P3_ANALOG <= 8'h00;
      O_RESONATOR_MODE <= 1'b0;
    end
    else
    begin
      O_P1_OE <= p1_dir_reg;
      // Divider output shares bit two, ANDed with latch bit two, which resets low
      O_P1_PIN <= {p1_latch_reg[6:3],
        p1_latch_reg[2] & I_DIVIDER_OUTPUT,
        p1_latch_reg[1:0]};
      O_P2_PIN <= p2_latch_reg;
      // Open-drain style: a low latch pulls the pin
      O_P2_OE[0] <= I_OUTPUT_DRIVE_ENABLE & ~I_STOP_MODE &
        ~p2_latch_reg[0];
      O_P2_OE[2:1] <= ctrl_reg[CTRL_DUAL_CLK] ? 2'b00 :
        (~p2_latch_reg[2:1] & {2{I_OUTPUT_DRIVE_ENABLE}});
      O_RESONATOR_MODE <= ctrl_reg[CTRL_DUAL_CLK];
      O_P3_PIN <= p3_latch_reg;
      O_P3_OE <= p3_dir_reg & ~analog_sel;
      O_P3_ANALOG <= analog_sel;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      O_EXT_INTERRUPT_ZERO <= 1'b0;
      O_EXT_INTERRUPT_ONE <= 1'b0;
      O_P20_EVENT <= 1'b0;
    end
    else
    begin
      O_EXT_INTERRUPT_ZERO <= event_reg[EV_EXT_INTERRUPT_ZERO];
      O_EXT_INTERRUPT_ONE <= event_reg[EV_EXT_INTERRUPT_ONE];
      O_P20_EVENT <= event_reg[EV_P20];
    end
  end

  // ==========================================================
  // Checks
  a_p1_reset_in: assert property (@(posedge I_CLK)
    I_SYS_RST |=> O_P1_OE == 7'h00 && O_P1_PIN == 7'h00)
    else $error("port one not input after reset");
  a_p2_latch_high: assert property (@(posedge I_CLK)
    I_SYS_RST |=> O_P2_PIN == 3'h7)
    else $error("port two latch not high after reset");
  a_p3_reset_dig: assert property (@(posedge I_CLK)
    I_SYS_RST |=> O_P3_OE == 8'h00 && O_P3_ANALOG == 8'h00)
    else $error("port three not digital input after reset");
  a_p1_dir_follow: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) 1'b1 |=> O_P1_OE == $past(p1_dir_reg))
    else $error("port one enable not from direction");
  a_ext_interrupt_one_edge: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    $changed(I_P1_PIN[1]) |=> ##1 O_EXT_INTERRUPT_ONE)
    else $error("interrupt one edge missed");
  a_ext_interrupt_zero_gated: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !ctrl_reg[CTRL_EXT_INTERRUPT_ZERO_SEL] && !event_reg[EV_EXT_INTERRUPT_ZERO] &&
    !ev_set[EV_EXT_INTERRUPT_ZERO] |=> !event_reg[EV_EXT_INTERRUPT_ZERO])
    else $error("interrupt zero set while pin is port");
  a_p20_fall: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    $fell(I_P2_PIN[0]) |=> ##1 O_P20_EVENT)
    else $error("port two bit zero falling edge missed");
  a_stop_float: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_STOP_MODE |=> !O_P2_OE[0])
    else $error("port two bit zero driven in stop");
  a_dual_float: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    ctrl_reg[CTRL_DUAL_CLK] |=> O_P2_OE[2:1] == 2'b00)
    else $error("resonator pins driven");
  a_analog_nodrv: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (O_P3_OE & O_P3_ANALOG) == 8'h00)
    else $error("analog pin driven");
  a_p3_out_drive: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    1'b1 |=> O_P3_OE == ($past(p3_dir_reg) & ~$past(analog_sel)))
    else $error("port three drive mismatch");
  a_p3_rd_input: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    take && !I_HWRITE && I_HADDR == ADDR_P3_DATA |=>
    O_HRDATA[7:0] == (($past(analog_sel) | $past(p3_dir_reg)) &
    $past(p3_latch_reg) | ~($past(analog_sel) | $past(p3_dir_reg)) &
    $past(I_P3_PIN)))
    else $error("port three read mismatch");
  a_p2_rd_high: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    take && !I_HWRITE && I_HADDR == ADDR_P2_PIN |=>
    O_HRDATA[31:3] == 29'h0 && O_HRDATA[2:0] == $past(I_P2_PIN))
    else $error("port two pin read mismatch");

  a_p2_reset_oe: assert property (@(posedge I_CLK)
    I_SYS_RST |=> O_P2_OE == 3'h0)
    else $error("port two driven after reset");
  a_p3_reset_pin: assert property (@(posedge I_CLK)
    I_SYS_RST |=> O_P3_PIN == 8'h00)
    else $error("port three latch not clear after reset");
  a_p2_pin_latch: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) 1'b1 |=> O_P2_PIN == $past(p2_latch_reg))
    else $error("port two drive not from latch");
  a_p3_pin_latch: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) 1'b1 |=> O_P3_PIN == $past(p3_latch_reg))
    else $error("port three drive not from latch");
  a_p1_latch_out: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) 1'b1 |=> {O_P1_PIN[6:3], O_P1_PIN[1:0]} ==
    {$past(p1_latch_reg[6:3]), $past(p1_latch_reg[1:0])})
    else $error("port one drive not from latch");
  a_p1_div_share: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) 1'b1 |=> O_P1_PIN[2] ==
    ($past(p1_latch_reg[2]) && $past(I_DIVIDER_OUTPUT)))
    else $error("divider output not on port one bit two");
  a_ext_interrupt_zero_edge: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) ctrl_reg[CTRL_EXT_INTERRUPT_ZERO_SEL] &&
    $changed(I_P1_PIN[0]) |=> ##1 O_EXT_INTERRUPT_ZERO)
    else $error("interrupt zero edge missed");
  a_ext_interrupt_one_sticky: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) event_reg[EV_EXT_INTERRUPT_ONE] && !ev_clr[EV_EXT_INTERRUPT_ONE] |=>
    event_reg[EV_EXT_INTERRUPT_ONE])
    else $error("interrupt one event lost");
  a_p20_sticky: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) event_reg[EV_P20] && !ev_clr[EV_P20] |=>
    event_reg[EV_P20])
    else $error("port two bit zero event lost");
  a_ev_clear: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) wr_pend_reg && addr_reg == ADDR_EVENT &&
    I_HWDATA[EV_EXT_INTERRUPT_ONE] && !ev_set[EV_EXT_INTERRUPT_ONE] |=> !event_reg[EV_EXT_INTERRUPT_ONE])
    else $error("interrupt one event not cleared");
  a_reso_mode: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) 1'b1 |=>
    O_RESONATOR_MODE == $past(ctrl_reg[CTRL_DUAL_CLK]))
    else $error("resonator mode not from control");
  a_p2_oe_drive: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) !ctrl_reg[CTRL_DUAL_CLK] |=> O_P2_OE[2:1] ==
    (~$past(p2_latch_reg[2:1]) & {2{$past(I_OUTPUT_DRIVE_ENABLE)}}))
    else $error("port two upper pins drive mismatch");
  a_analog_onehot: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) $onehot0(O_P3_ANALOG))
    else $error("more than one analog pin");
  a_analog_sel: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) 1'b1 |=> O_P3_ANALOG == $past(analog_sel))
    else $error("analog pin selection mismatch");
  a_p2_rd_latch: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) take && !I_HWRITE &&
    I_HADDR == ADDR_P2_DATA |=> O_HRDATA == {29'h0, $past(p2_latch_reg)})
    else $error("port two latch read mismatch");
  a_p1_rd_mix: assert property (@(posedge I_CLK)
    disable iff (I_SYS_RST) take && !I_HWRITE &&
    I_HADDR == ADDR_P1_DATA |=> O_HRDATA[7:0] == {1'b0,
    $past(p1_dir_reg) & $past(p1_latch_reg) |
    ~$past(p1_dir_reg) & $past(I_P1_PIN)})
    else $error("port one read mismatch");

  c_p3_analog: cover property (@(posedge I_CLK) O_P3_ANALOG != 8'h00);
  c_ext_interrupt_one_event: cover property (@(posedge I_CLK) O_EXT_INTERRUPT_ONE);
  c_stop_mode: cover property (@(posedge I_CLK) I_STOP_MODE);
  c_p1_output: cover property (@(posedge I_CLK) O_P1_OE != 7'h00);
  c_p20_event: cover property (@(posedge I_CLK) O_P20_EVENT);
endmodule

/* verification/mpgpio_pins.sv */
// Purpose: far-side pin model for ports one, two and three
// Assumes: packed as {port three, port two, port one}
// Notes: released pins show the bench's pull level
`timescale 1ns/10ps
module mpgpio_pins
(
  // Block drive
  input wire logic [17:0] i_drv,
  input wire logic [17:0] i_oe,
  // Pull levels
  input wire logic [17:0] i_pull,
  // Resolved levels
  output logic [17:0] o_lvl
);
  // ==========================================================
  // Resolution
  // Driver wins; contention is not modelled
  assign o_lvl = (i_oe & i_drv) | (~i_oe & i_pull);
endmodule

/* verification/mpgpio_tb_top.sv */
// Purpose: register and pin tests of the three-port block
// Assumes: zero wait state bus, pins resolved by the pin model
// Notes: one word transfers only
`timescale 1ns/10ps
module mpgpio_tb_top
  import mpgpio_pkg::*;
;
  logic clk = 0, rst = 1, hsel = 1, hwrite = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, hrdata, rd;
  logic hready, hresp, ei0, ei1, ev2, reso;
  logic stop = 0, den = 1, divider_output = 0, conv = 0;
  logic [6:0] p1o, p1e;
  logic [2:0] p2o, p2e;
  logic [7:0] p3o, p3e, p3a;
  logic [17:0] pull = 0, lvl;
  int fails = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  mpgpio_top uut (.I_CLK(clk), .I_SYS_RST(rst), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_P1_PIN(lvl[6:0]), .O_P1_PIN(p1o), .O_P1_OE(p1e),
    .I_P2_PIN(lvl[9:7]), .O_P2_PIN(p2o), .O_P2_OE(p2e),
    .I_P3_PIN(lvl[17:10]), .O_P3_PIN(p3o), .O_P3_OE(p3e),
    .O_P3_ANALOG(p3a), .I_STOP_MODE(stop),
    .I_OUTPUT_DRIVE_ENABLE(den), .I_DIVIDER_OUTPUT(divider_output),
    .I_CONVERTING(conv), .O_EXT_INTERRUPT_ZERO(ei0),
    .O_EXT_INTERRUPT_ONE(ei1), .O_P20_EVENT(ev2),
    .O_RESONATOR_MODE(reso));
  mpgpio_pins pins (.i_drv({p3o, p2o, p1o}), .i_oe({p3e, p2e, p1e}),
    .i_pull(pull), .o_lvl(lvl));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata;
    chk(hresp, 0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  // Pins and events need up to three edges past the write
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic flip(input logic [17:0] m);
    @(posedge clk);
    pull <= pull ^ m;
    settle;
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial
  begin
    logic [7:0] a;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    pull <= {8'h38, 3'h5, 7'h2A};
    rdc(ADDR_P1_DIR, 0);
    rdc(ADDR_P3_DIR, 0);
    rdc(ADDR_CTRL, 32'h2);
    rdc(ADDR_P2_DATA, 32'h7);
    rdc(8'h50, 0);
    chk({p1e, p1o}, 0);
    chk({p3e, p3a, p3o}, 0);
    $display("test reset done");
    wr(ADDR_P1_DATA, 32'h55);
    wr(ADDR_P1_DIR, 32'h0E);
    settle;
    chk({p1e, p1o}, {7'h0E, 7'h51});
    @(posedge clk);
    divider_output <= 1'h1;
    settle;
    chk(p1o, 7'h55);
    rdc(ADDR_P1_DATA, 32'h24);
    wr(ADDR_EVENT, 32'h7);
    rdc(ADDR_EVENT, 0);
    wr(ADDR_P1_DATA, 32'h57);
    settle;
    rdc(ADDR_EVENT, 32'h2);
    chk(ei1, 1);
    flip(18'h1);
    rdc(ADDR_EVENT, 32'h2);
    wr(ADDR_CTRL, 32'h3);
    flip(18'h1);
    rdc(ADDR_EVENT, 32'h3);
    chk(ei0, 1);
    wr(ADDR_EVENT, 32'h7);
    $display("test port one done");
    wr(ADDR_P2_DATA, 32'h6);
    settle;
    chk({p2e, p2o}, {3'h1, 3'h6});
    rdc(ADDR_P2_DATA, 32'h6);
    rdc(ADDR_P2_PIN, 32'h4);
    rdc(ADDR_EVENT, 32'h4);
    chk(ev2, 1);
    @(posedge clk);
    stop <= 1'h1;
    settle;
    chk(p2e, 0);
    @(posedge clk);
    stop <= 1'h0;
    wr(ADDR_P2_DATA, 0);
    settle;
    chk(p2e, 3'h7);
    wr(ADDR_CTRL, 32'h7);
    settle;
    chk({reso, p2e}, 4'h9);
    $display("test port two done");
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_P3_DATA, 32'hA5);
    wr(ADDR_P3_DIR, 32'hF0);
    settle;
    chk({p3e, p3o}, 16'hF0A5);
    rdc(ADDR_P3_DATA, 32'hA8);
    wr(ADDR_P3_DIR, 32'hF4);
    @(posedge clk);
    conv <= 1'h1;
    wr(ADDR_CTRL, 0);
    settle;
    rdc(ADDR_P3_DATA, 32'hAC);
    for (int ch = 0; ch < 8; ch++)
    begin
      wr(ADDR_CTRL, ch << CTRL_CH_LSB);
      settle;
      a = (ch < AIN_COUNT) ? (8'h1 << (ch + AIN_BASE)) : 8'h0;
      chk({p3a, p3e}, {a, 8'hF4 & ~a});
    end
    wr(ADDR_CTRL, 32'h52);
    settle;
    chk(p3a, 0);
    @(posedge clk);
    conv <= 1'h0;
    wr(ADDR_P3_DIR, 32'h0F);
    settle;
    chk(p3e, 8'h0F);
    $display("test port three done");
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rdc(ADDR_P1_DIR, 0);
    rdc(ADDR_CTRL, 32'h2);
    chk({p3e, p3a}, 0);
    $display("test second reset done");
    print_verdict;
  end
  // Tests take under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    print_verdict;
  end
endmodule
